// *** hdl/ecp_parallel_port_link.sv ***
// Purpose: Extended capabilities parallel port: registers, shared FIFO, cable handshakes.
// Assumes: Host strobes and cable inputs are synchronous to mclk.
// Notes:   Registers answer one clock after a strobe; FIFO holds a tag bit per byte.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_consts.svh"

module ecp_parallel_port_link #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Host register port.
  input  wire logic [10:0]  bus_addr,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  input  wire logic [7:0]   bus_wdata,
  output logic      [7:0]   bus_rdata,
  // DMA handshake.
  output logic              dma_req,
  input  wire logic         dma_ack,
  // Cable data lines.
  input  wire logic [7:0]   pd_in,
  output logic      [7:0]   pd_out,
  output logic              pd_oe,
  // Cable control outputs.
  output logic              nstrobe_out,
  output logic              nautofd_out,
  output logic              ninit_out,
  output logic              nselectin_out,
  // Cable status inputs.
  input  wire logic         nack_in,
  input  wire logic         busy_in,
  input  wire logic         perror_in,
  input  wire logic         select_in,
  input  wire logic         nfault_in,
  // Interrupt request level.
  output logic              irq_line_level
);
  import ecp_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int W  = 9;

  // The pointer logic wraps by overflow, so the depth must be a power of two.
  if ((1 << AW) != FIFO_DEPTH || FIFO_DEPTH < 2) begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2.");
  end

  // All state of the port.
  typedef struct packed {
    mode_t         mode;     // Mode field.
    logic [5:0]    dcr;      // Writable bits of line_control.
    logic [7:0]    data;     // Port word latch.
    logic          nerr;     // Fault interrupt disable, active high.
    logic          dma;      // DMA allow.
    logic          svc;      // Service request flag.
    logic [AW:0]   wp;       // Write pointer with wrap bit.
    logic [AW:0]   rp;       // Read pointer with wrap bit.
    xfer_st_t      st;       // Cable handshake state.
    logic [7:0]    fwd;      // Byte being sent.
    logic          ftag;     // Sent byte is address or RLE count.
    logic [7:0]    rev;      // Byte received.
    logic          rbusy;    // Busy level captured with it.
    logic [6:0]    rle;      // Repeats still to push.
    logic          rle_pend; // A count waits for its data byte.
    logic [7:0]    rdata;    // Host read answer.
    logic [7:0]    last;     // Last byte read from the FIFO.
    logic [7:0]    pdo;      // Data line output register.
    logic          nstb;     // Handshake strobe level.
    logic          nafd;     // Handshake autofeed level.
  } state_t;

  localparam state_t S_RST = '{
    mode: MODE_SPP, st: ST_IDLE, nstb: 1'b1, nafd: 1'b1, data: `DATA_RESET,
    default: '0
  };

  state_t s_q;
  state_t s_d;

  // Storage of the shared FIFO.
  fifo_mem_if #(.W(W), .AW(AW)) mif ();

  fifo_mem #(
    .W     (W),
    .DEPTH (FIFO_DEPTH)
  ) u_mem (
    .mclk  (mclk),
    .rst_n (rst_n),
    .mp    (mif.mem)
  );

  // Derived conditions.
  logic [AW:0] count;     // Bytes held.
  logic        full;      // No room left.
  logic        empty;     // Nothing held.
  logic        dir_rev;   // Effective direction is reverse.
  logic        hs_mode;   // A hardware handshake mode is selected.
  logic        fifo_acc;  // Host access goes to the FIFO port.
  logic        push;      // FIFO write this cycle.
  logic        pop;       // FIFO read this cycle.
  logic [W-1:0] push_v;   // Entry written.

  assign count    = s_q.wp - s_q.rp;
  assign empty    = (s_q.wp == s_q.rp);
  assign full     = (count == (AW+1)'(FIFO_DEPTH));
  // Direction is forced out in the two compatibility modes.
  assign dir_rev  = s_q.dcr[`DCR_DIR] &&
                    !(s_q.mode == MODE_SPP || s_q.mode == MODE_COMPAT_FIFO_PORT);
  assign hs_mode  = (s_q.mode == MODE_COMPAT_FIFO_PORT) || (s_q.mode == MODE_ECP);
  // DMA acknowledge always reaches the FIFO port whatever the address.
  assign fifo_acc = dma_ack || (bus_addr == `OFS_FIFO);

  // Next state: host access first, then the cable, then flags.
  always_comb begin
    s_d    = s_q;
    push   = 1'b0;
    pop    = 1'b0;
    push_v = '0;

    // Host writes; the decode depends on the mode field.
    if (bus_wr) begin
      if (fifo_acc && (hs_mode || s_q.mode == MODE_TEST)) begin
        // Forward FIFO modes, or test mode in any direction; a full FIFO drops it.
        if (!full && (!dir_rev || s_q.mode == MODE_TEST)) begin
          push   = 1'b1;
          push_v = {1'b0, bus_wdata};
        end
      end else begin
        case (bus_addr)
          `OFS_DATA: begin
            if (s_q.mode == MODE_ECP) begin
              // Address or RLE byte, tagged, forward only.
              if (!full && !dir_rev) begin
                push   = 1'b1;
                push_v = {1'b1, bus_wdata};
              end
            end else begin
              s_d.data = bus_wdata;
            end
          end
          `OFS_DCR: begin
            s_d.dcr = bus_wdata[5:0];
          end
          `OFS_ECR: begin
            s_d.mode = mode_t'(bus_wdata[7:5]);
            s_d.nerr = bus_wdata[`ECR_NERR];
            s_d.dma  = bus_wdata[`ECR_DMA];
            // Writing one clears the service request flag.
            if (bus_wdata[`ECR_SVC]) begin
              s_d.svc = 1'b0;
            end
          end
          default: begin
            // Status and capability registers ignore writes.
          end
        endcase
      end
    end

    // Host reads; the answer is registered.
    if (bus_rd) begin
      // Configuration mode answers at both capability offsets, and DMA at any other address answers capability_a.
      if (s_q.mode == MODE_CFG && (fifo_acc || bus_addr == `OFS_CAPABILITY_B)) begin
        s_d.rdata = (bus_addr == `OFS_CAPABILITY_B) ? {1'b0, irq_line_level, 6'h00}
                                               : `CAPABILITY_A_VALUE;
      end else if (fifo_acc && (s_q.mode == MODE_TEST ||
                                (s_q.mode == MODE_ECP && dir_rev))) begin
        // An empty FIFO rereads the last byte instead of stalling.
        if (!empty) begin
          pop        = 1'b1;
          s_d.rdata  = mif.rdata[7:0];
          s_d.last   = mif.rdata[7:0];
        end else begin
          s_d.rdata  = s_q.last;
        end
      end else begin
        case (bus_addr)
          `OFS_DATA:  s_d.rdata = (s_q.mode == MODE_ECP) ? 8'h00 : pd_in;
          `OFS_DSR:   s_d.rdata = {~busy_in, nack_in, perror_in, select_in,
                                   nfault_in, 3'h0};
          `OFS_DCR:   s_d.rdata = {2'h0, s_q.dcr};
          `OFS_ECR:   s_d.rdata = {s_q.mode, s_q.nerr, s_q.dma, s_q.svc,
                                   full, empty};
          default:    s_d.rdata = 8'h00;
        endcase
      end
    end

    // Cable handshake.
    case (s_q.st)
      ST_IDLE: begin
        if (hs_mode && !dir_rev && !empty) begin
          // Take the head byte and put it and its tag on the lines.
          pop        = 1'b1;
          s_d.fwd    = mif.rdata[7:0];
          s_d.ftag   = mif.rdata[8];
          s_d.nafd   = (s_q.mode == MODE_ECP) ? !mif.rdata[8] : 1'b1;
          s_d.st     = ST_FSET;
        end else if (s_q.mode == MODE_ECP && dir_rev && !full && !perror_in) begin
          // Reverse is acknowledged; ask for a byte only while room remains.
          s_d.nafd   = 1'b0;
          s_d.st     = ST_RREQ;
        end
      end
      ST_FSET: begin
        // Data have stood a cycle; strobe once the peripheral is not busy.
        if (!busy_in) begin
          s_d.nstb = 1'b0;
          s_d.st   = ST_FWAIT;
        end
      end
      ST_FWAIT: begin
        // Busy rising says the byte was taken; release the strobe.
        if (busy_in) begin
          s_d.nstb = 1'b1;
          s_d.st   = ST_IDLE;
        end
      end
      ST_RREQ: begin
        // nAck low means the data are valid; Busy says command or data.
        if (!nack_in) begin
          s_d.rev   = pd_in;
          s_d.rbusy = busy_in;
          s_d.nafd  = 1'b1;
          s_d.st    = ST_REND;
        end
      end
      ST_REND: begin
        if (nack_in) begin
          s_d.st = ST_IDLE;
          if (!s_q.rbusy) begin
            // Command byte: a count if bit 7 is clear, else a channel address.
            if (!s_q.rev[7]) begin
              s_d.rle      = s_q.rev[6:0];
              s_d.rle_pend = 1'b1;
            end
          end else if (s_q.rle_pend) begin
            s_d.rle_pend = 1'b0;
            s_d.st       = ST_RRLE;
          end else begin
            push   = 1'b1;
            push_v = {1'b0, s_q.rev};
          end
        end
      end
      ST_RRLE: begin
        // Push the byte count plus one times, waiting whenever the FIFO fills.
        if (!full) begin
          push   = 1'b1;
          push_v = {1'b0, s_q.rev};
          if (s_q.rle == 7'h00) begin
            s_d.st = ST_IDLE;
          end else begin
            s_d.rle = s_q.rle - 7'h01;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Leaving the handshake modes abandons any transfer in flight.
    if (!hs_mode) begin
      s_d.st       = ST_IDLE;
      s_d.nstb     = 1'b1;
      s_d.nafd     = 1'b1;
      s_d.rle_pend = 1'b0;
    end

    // Pointer movement; a mode change empties the FIFO.
    if (push) begin
      s_d.wp = s_q.wp + (AW+1)'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + (AW+1)'(1);
    end
    if (s_d.mode != s_q.mode) begin
      s_d.wp = '0;
      s_d.rp = '0;
    end

    // Without DMA, software is asked to service the FIFO at the threshold.
    // The set is applied last so it wins over a clear in the same cycle.
    if (!s_q.dma && hs_mode &&
        (dir_rev ? (count >= (AW+1)'(`SVC_LEVEL)) : (count <= (AW+1)'(`SVC_LEVEL)))) begin
      s_d.svc = 1'b1;
    end

    // Data line register: port word latch, byte in flight, or FIFO head in test.
    case (s_d.mode)
      MODE_COMPAT_FIFO_PORT, MODE_ECP: s_d.pdo = s_d.fwd;
      MODE_TEST:            s_d.pdo = mif.rdata[7:0];
      default:              s_d.pdo = s_d.data;
    endcase
  end

  // Storage port follows the pointers; read address is the next head.
  always_comb begin
    mif.we    = push;
    mif.waddr = s_q.wp[AW-1:0];
    mif.wdata = push_v;
    mif.raddr = s_d.rp[AW-1:0];
  end

  // Single state register with synchronous reset.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Host answer and DMA request.
  assign bus_rdata = s_q.rdata;
  // DMA asks for room going forward and for data coming back.
  assign dma_req   = s_q.dma && hs_mode &&
                     (dir_rev ? !empty : !full);

  // Data lines are driven only forward, and in ECP only once PError shows forward.
  assign pd_out = s_q.pdo;
  assign pd_oe  = !dir_rev &&
                  (s_q.mode != MODE_ECP || perror_in);

  // Control lines: both handshake modes strobe from the state machine, ECP also autofeed; others use the control bits.
  assign nstrobe_out   = hs_mode ? s_q.nstb : !s_q.dcr[`DCR_STROBE];
  assign nautofd_out   = (s_q.mode == MODE_ECP) ? s_q.nafd : !s_q.dcr[`DCR_AUTOFD];
  // nInit low turns the channel round; the host alone decides when.
  assign ninit_out     = (s_q.mode == MODE_ECP) ? !dir_rev
                                                 : s_q.dcr[`DCR_NINIT];
  assign nselectin_out = (s_q.mode == MODE_ECP) ? 1'b1 : !s_q.dcr[`DCR_SELIN];

  // A low nFault while forward is an error or a reverse hint; either may interrupt.
  assign irq_line_level = s_q.svc ||
                          (!s_q.nerr && !nfault_in && !dir_rev);

endmodule : ecp_parallel_port_link
`default_nettype wire

// *** hdl/ecp_consts.svh ***
// Purpose: Offsets, field positions, reset values and fixed read values of the port.
// Assumes: Offsets are relative to the port base address, as seen on bus_addr.
// Notes:   Definitions only; no logic lives here.
`ifndef ECP_CONSTS_SVH
`define ECP_CONSTS_SVH

// Register offsets on the 11-bit host address.
`define OFS_DATA     11'h000
`define OFS_DSR      11'h001
`define OFS_DCR      11'h002
`define OFS_FIFO     11'h400
`define OFS_CAPABILITY_B    11'h401
`define OFS_ECR      11'h402

// Line control field positions.
`define DCR_STROBE   0
`define DCR_AUTOFD   1
`define DCR_NINIT    2
`define DCR_SELIN    3
`define DCR_DIR      5

// Extended control field positions.
`define ECR_NERR     4
`define ECR_DMA      3
`define ECR_SVC      2

// Fixed read value of capability_a and reset of the port word latch.
`define CAPABILITY_A_VALUE  8'h10
`define DATA_RESET   8'h00

// Fill level that raises the service request flag.
`define SVC_LEVEL    8'h08

`endif

// *** hdl/ecp_pkg.sv ***
// Purpose: Shared types of the extended capabilities port.
// Assumes: Mode codes match the three-bit mode field of extended_control.
// Notes:   Transfer states are one-hot.
package ecp_pkg;

  // Mode field of extended_control.
  typedef enum logic [2:0] {
    MODE_SPP   = 3'h0,
    MODE_PS2   = 3'h1,
    MODE_COMPAT_FIFO_PORT = 3'h2,
    MODE_ECP   = 3'h3,
    MODE_EPP   = 3'h4,
    MODE_RSVD  = 3'h5,
    MODE_TEST  = 3'h6,
    MODE_CFG   = 3'h7
  } mode_t;

  // Cable handshake states.
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_FSET  = 6'h02,
    ST_FWAIT = 6'h04,
    ST_RREQ  = 6'h08,
    ST_REND  = 6'h10,
    ST_RRLE  = 6'h20
  } xfer_st_t;

endpackage : ecp_pkg

// *** hdl/fifo_mem_if.sv ***
// Purpose: Carries one write port and one read port between controller and FIFO storage.
// Assumes: Read data arrive one clock after the read address.
// Notes:   The controller owns the pointers; the storage only stores.
`timescale 1ns/1ps
`default_nettype none
interface fifo_mem_if #(
  parameter int W  = 9,
  parameter int AW = 4
);
  logic          we;     // Write strobe.
  logic [AW-1:0] waddr;  // Write address.
  logic [W-1:0]  wdata;  // Write data.
  logic [AW-1:0] raddr;  // Read address, sampled every clock.
  logic [W-1:0]  rdata;  // Registered read data.

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : fifo_mem_if
`default_nettype wire

// *** hdl/fifo_mem.sv ***
// Purpose: Storage of the shared byte FIFO, one write and one registered read port.
// Assumes: Write and read addresses come from the controlling pointers.
// Notes:   A write to the address being read is passed straight through.
`timescale 1ns/1ps
`default_nettype none
module fifo_mem #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Storage port.
  fifo_mem_if.mem  mp
);
  localparam int AW = $clog2(DEPTH);

  // All storage of this module.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] arr;  // Entries.
    logic [W-1:0]            rd;   // Read register.
  } mem_t;

  mem_t s_q;
  mem_t s_d;

  // Next contents: write, then read with bypass so a fresh entry is seen at once.
  always_comb begin
    s_d = s_q;
    if (mp.we) begin
      s_d.arr[mp.waddr] = mp.wdata;
    end
    s_d.rd = s_d.arr[mp.raddr];
  end

  // Only the read register needs a defined value; entries are written before use.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q.rd  <= '0;
      s_q.arr <= s_d.arr;
    end else begin
      s_q <= s_d;
    end
  end

  assign mp.rdata = s_q.rd;
endmodule : fifo_mem
`default_nettype wire

// *** dv/ecp_port_chk.sv ***
// Purpose: Pin-level assertions for the parallel port link.
// Assumes: Mode, direction and fault enable are shadowed from host writes.
// Notes:   Bound to the top module; watches its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_consts.svh"
module ecp_port_chk (
  // Clock, reset and host port.
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [10:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  // Cable side and interrupt.
  input wire logic        pd_oe,
  input wire logic        nstrobe_out,
  input wire logic        nautofd_out,
  input wire logic        ninit_out,
  input wire logic        nselectin_out,
  input wire logic        nack_in,
  input wire logic        busy_in,
  input wire logic        perror_in,
  input wire logic        select_in,
  input wire logic        nfault_in,
  input wire logic        irq_line_level
);
  logic [2:0] mode_q;  // Shadow of the mode field.
  logic       dir_q;   // Shadow of the direction bit.
  logic       nerr_q;  // Shadow of the fault disable; clear after reset, like the port.

  // Shadows move on the same edge as the port's own registers.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
      nerr_q <= 1'b0;
      dir_q  <= 1'b0;
    end else if (bus_wr && bus_addr == `OFS_ECR) begin
      mode_q <= bus_wdata[7:5];
      nerr_q <= bus_wdata[`ECR_NERR];
    end else if (bus_wr && bus_addr == `OFS_DCR) begin
      dir_q <= bus_wdata[`DCR_DIR];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sel_off_a: assert property (mode_q == 3'h3 |-> nselectin_out)
    else $error("select line asserted in burst mode");
  out_only_a: assert property ((mode_q == 3'h0 || mode_q == 3'h2) |-> pd_oe)
    else $error("data lines released in an output-only mode");
  rev_release_a: assert property (mode_q == 3'h3 && (dir_q || !perror_in) |-> !pd_oe)
    else $error("data lines driven without permission");
  ninit_dir_a: assert property (mode_q == 3'h3 |-> ninit_out == !dir_q)
    else $error("direction line disagrees with direction bit");
  status_read_a: assert property (bus_rd && bus_addr == `OFS_DSR |=> bus_rdata ==
      {!$past(busy_in), $past(nack_in), $past(perror_in), $past(select_in), $past(nfault_in), 3'h0})
    else $error("status read does not mirror the lines");
  strobe_ready_a: assert property ($fell(nstrobe_out) && mode_q[2:1] == 2'h1 && $stable(mode_q)
      |-> !$past(busy_in))
    else $error("strobe asserted while peripheral busy");
  hostack_req_a: assert property ($fell(nautofd_out) && mode_q == 3'h3 && dir_q && $stable(dir_q)
      |-> !$past(perror_in))
    else $error("byte requested before reverse acknowledged");
  hostack_done_a: assert property ($rose(nautofd_out) && mode_q == 3'h3 && dir_q && $stable(dir_q)
      |-> !$past(nack_in))
    else $error("request released before peripheral clock");
  cap_read_a: assert property (bus_rd && bus_addr == `OFS_FIFO && mode_q == 3'h7
      |=> bus_rdata == `CAPABILITY_A_VALUE)
    else $error("capability read wrong");
  fault_irq_a: assert property (!nfault_in && !$past(nfault_in) && mode_q == 3'h0 && !nerr_q
      && $stable(nerr_q) |-> irq_line_level)
    else $error("fault did not raise the interrupt");
endmodule : ecp_port_chk

bind ecp_parallel_port_link ecp_port_chk u_chk (
  .mclk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .pd_oe, .nstrobe_out,
  .nautofd_out, .ninit_out, .nselectin_out, .nack_in, .busy_in, .perror_in, .select_in,
  .nfault_in, .irq_line_level
);
`default_nettype wire

// *** dv/ecp_periph_model.sv ***
// Purpose: Behavioural peripheral at the far end of the cable.
// Assumes: Port outputs change just after mclk edges.
// Notes:   The bench fills rev_q and reads fwd_q by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module ecp_periph_model #(
  parameter int DLY = 2  // Cycles taken to answer each strobe edge and the autofeed fall.
) (
  // Clock and lines from the port.
  input  wire logic       mclk,
  input  wire logic [7:0] pd_out,
  input  wire logic       nstrobe_out,
  input  wire logic       nautofd_out,
  input  wire logic       ninit_out,
  input  wire logic       rev_hint,
  // Lines back to the port.
  output logic      [7:0] pd_drv,
  output logic            nack_in,
  output logic            busy_in,
  output logic            perror_in,
  output logic            select_in,
  output var logic        nfault_in
);
  logic [8:0] fwd_q[$];  // Received bytes as {address tag, byte}.
  logic [8:0] rev_q[$];  // Bytes to send as {busy level, byte}; busy low marks a command.

  // A reverse hint only makes sense while the channel is forward.
  assign nfault_in = !(rev_hint && ninit_out);

  // One handshake at a time; perror follows the direction line when idle.
  initial begin
    nack_in   = 1'b1;
    busy_in   = 1'b0;
    perror_in = 1'b1;
    select_in = 1'b1;
    pd_drv    = 8'h00;
    forever begin
      @(posedge mclk);
      perror_in <= ninit_out;
      if (ninit_out && !nstrobe_out && !busy_in) begin
        fwd_q.push_back({!nautofd_out, pd_out});
        repeat (DLY) @(posedge mclk);
        busy_in <= 1'b1;
        do @(posedge mclk); while (!nstrobe_out);
        repeat (DLY) @(posedge mclk);
        busy_in <= 1'b0;
      end else if (!ninit_out && !perror_in && !nautofd_out && rev_q.size() > 0) begin
        {busy_in, pd_drv} <= rev_q.pop_front();
        repeat (DLY) @(posedge mclk);
        nack_in <= 1'b0;
        do @(posedge mclk); while (!nautofd_out);
        nack_in <= 1'b1;
        busy_in <= 1'b0;
        pd_drv  <= ~pd_drv;  // Released lines must not keep the last byte.
      end
    end
  end
endmodule : ecp_periph_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the parallel port link.
// Assumes: Far side is the behavioural peripheral model.
// Notes:   Register rows run first, then FIFO and cable scenarios.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk, rst_n, bus_wr, bus_rd, dma_ack, rev_hint;
  logic [10:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, pd_out, pd_drv, v;
  logic        pd_oe, dma_req, nstrobe_out, nautofd_out, ninit_out, nselectin_out;
  logic        nack_in, busy_in, perror_in, select_in, nfault_in, irq_line_level;
  wire logic [7:0] pd_wire = pd_oe ? pd_out : pd_drv;  // Resolved cable data.
  int          fail_count, n_compared, cyc;
  typedef struct { logic w; logic [10:0] a; logic [7:0] d; } row_t;
  // Writes carry data, reads carry the expected answer.
  row_t rows[13] = '{'{1'b0, 11'h002, 8'h00}, '{1'b1, 11'h000, 8'ha5}, '{1'b0, 11'h000, 8'ha5},
    '{1'b1, 11'h002, 8'hfe}, '{1'b0, 11'h002, 8'h3e}, '{1'b0, 11'h000, 8'ha5},
    '{1'b1, 11'h002, 8'h00}, '{1'b0, 11'h001, 8'hd8}, '{1'b1, 11'h402, 8'he0},
    '{1'b0, 11'h400, 8'h10}, '{1'b0, 11'h401, 8'h00}, '{1'b0, 11'h402, 8'he1},
    '{1'b0, 11'h7ff, 8'h00}};

  ecp_parallel_port_link u_dut (.mclk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata, .dma_req, .dma_ack, .pd_in(pd_wire), .pd_out, .pd_oe, .nstrobe_out,
    .nautofd_out, .ninit_out, .nselectin_out, .nack_in, .busy_in, .perror_in, .select_in,
    .nfault_in, .irq_line_level);
  ecp_periph_model u_per (.mclk, .pd_out, .nstrobe_out, .nautofd_out, .ninit_out, .rev_hint,
    .pd_drv, .nack_in, .busy_in, .perror_in, .select_in, .nfault_in);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask : wr

  // Reads answer one cycle after the strobe edge; dma forces the FIFO.
  task automatic rd(input logic [10:0] a, input logic dma, output logic [7:0] r);
    @(posedge mclk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    dma_ack  <= dma;
    @(posedge mclk);
    bus_rd  <= 1'b0;
    dma_ack <= 1'b0;
    #1 r = bus_rdata;
  endtask : rd

  // Waits, bounded, for n forward bytes and an idle cable.
  task automatic wait_fwd(input int n);
    for (int i = 0; i < 400 && !(u_per.fwd_q.size() >= n && !busy_in && nstrobe_out); i++)
      @(posedge mclk);
    check(9'(u_per.fwd_q.size()), 9'(n));
  endtask : wait_fwd

  // A hang counts as a mismatch.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  initial begin
    {rst_n, bus_wr, bus_rd, dma_ack, rev_hint} = 5'h0;
    bus_addr  = 11'h000;
    bus_wdata = 8'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    check({2'h0, nselectin_out, nstrobe_out, nautofd_out, ninit_out, irq_line_level, dma_req,
           pd_oe}, 9'h071);
    check({1'b0, pd_out}, 9'h000);
    check({1'b0, bus_rdata}, 9'h000);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, 1'b0, v);
        check({1'b0, v}, {1'b0, rows[i].d});
      end
    end
    // Fault interrupt in printer mode, direction left alone.
    wr(11'h002, 8'h04);
    wr(11'h402, 8'h00);
    rev_hint <= 1'b1;
    repeat (3) @(posedge mclk);
    check({7'h0, irq_line_level, ninit_out}, 9'h003);
    // Capability_b shows the raised interrupt level in configuration mode.
    wr(11'h402, 8'he0);
    rd(11'h401, 1'b0, v);
    check({1'b0, v}, 9'h040);
    // The disable bit alone must hold the interrupt down while the hint stays.
    wr(11'h402, 8'h10);
    repeat (2) @(posedge mclk);
    check({8'h0, irq_line_level}, 9'h000);
    rev_hint <= 1'b0;
    // Test FIFO: overfill, then drain past empty.
    wr(11'h402, 8'hc0);
    for (int i = 0; i < 17; i++) wr(11'h400, 8'h30 + 8'(i));
    rd(11'h402, 1'b0, v);
    check({1'b0, v}, 9'h0c2);
    for (int i = 0; i < 17; i++) begin
      rd(11'h400, 1'b0, v);
      check({1'b0, v}, 9'h030 + 9'(i < 16 ? i : 15));
    end
    rd(11'h402, 1'b0, v);
    check({1'b0, v}, 9'h0c1);
    // Compatibility FIFO strobes by itself; direction bit ignored.
    wr(11'h002, 8'h24);
    wr(11'h402, 8'h40);
    foreach (rows[i]) if (i < 3) wr(11'h400, 8'h5a ^ {i[1:0], 6'h0});
    wait_fwd(3);
    for (int i = 0; i < 3; i++) check(u_per.fwd_q[i], {1'b0, 8'h5a ^ {2'(i), 6'h0}});
    // Burst forward: address byte then data byte.
    wr(11'h002, 8'h04);
    wr(11'h402, 8'h60);
    wr(11'h000, 8'h12);
    wr(11'h400, 8'h34);
    wait_fwd(5);
    check(u_per.fwd_q[3], 9'h112);
    check(u_per.fwd_q[4], 9'h034);
    // Burst reverse with a run count and a dropped channel byte, read by DMA.
    u_per.rev_q = '{9'h002, 9'h1ab, 9'h1cd, 9'h085};
    wr(11'h402, 8'h68);
    wr(11'h002, 8'h20);
    for (int i = 0; i < 400 && (u_per.rev_q.size() > 0 || !nack_in); i++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    check({8'h0, dma_req}, 9'h001);
    for (int i = 0; i < 4; i++) begin
      rd(11'h000, 1'b1, v);
      check({1'b0, v}, i < 3 ? 9'h0ab : 9'h0cd);
    end
    check({8'h0, dma_req}, 9'h000);
    wr(11'h402, 8'h00);
    #1 check({8'h0, pd_oe}, 9'h001);
    // Outside the two output-only modes the direction bit turns the lines round.
    wr(11'h402, 8'h20);
    #1 check({8'h0, pd_oe}, 9'h000);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
